// >>> src/dsl_defs.vh
// Constants for the serial load control of the synthesizer core.
// Assumes a single 20 MHz clock and an APB master for the status registers.
`ifndef DSL_DEFS_VH
`define DSL_DEFS_VH

`define DSL_WORD_BITS      16
`define DSL_LAST_BIT       5'h0f
`define DSL_CMD_PH_DEFER   4'h0
`define DSL_CMD_PH_DIRECT  4'h1
`define DSL_CMD_FR_DEFER   4'h2
`define DSL_CMD_FR_DIRECT  4'h3
`define DSL_CMD_SEL_BITS   4'h6
`define DSL_TOP_SYNC_SRC   2'h2
`define DSL_TOP_POWER      2'h3
`define DSL_BIT_SYNC       13
`define DSL_BIT_SOURCE     12
`define DSL_BIT_SLEEP      13
`define DSL_BIT_RESET      12
`define DSL_BIT_CLEAR      11
`define DSL_BIT_FCHOICE    11
`define DSL_ADDR_UPPER     0
`define DSL_ADDR_BANK      2
`define DSL_OFF_STATUS     12'h000
`define DSL_OFF_PHASE      12'h004
`define DSL_OFF_ACC        12'h008
`define DSL_OFF_FREQ       12'h00c
`define DSL_OFF_CTRL       12'h010
`define DSL_CTRL_RESET     1'h1
`define DSL_RESET_CTL_INIT 1'h1

`endif

// >>> src/dsl_serial_rx.v
// Serial word receiver for the load control block.
// Assumes serial clock, data and frame are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "dsl_defs.vh"
module dsl_serial_rx (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        sclk,
    input  wire        serial_data_in,
    input  wire        frame_sync_n,
    output reg         word_valid,
    output reg  [15:0] word_data
);
    reg        sclk_prev_reg;
    reg [4:0]  count_reg;
    reg [15:0] shift_reg;
    wire       fall_edge = sclk_prev_reg & ~sclk;

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            sclk_prev_reg <= 1'b0;
            count_reg     <= 5'h00;
            shift_reg     <= 16'h0000;
            word_valid    <= 1'b0;
            word_data     <= 16'h0000;
        end
        else
        begin
            sclk_prev_reg <= sclk;
            word_valid    <= 1'b0;
            if (frame_sync_n)
                count_reg <= 5'h00;
            else if (fall_edge && count_reg <= `DSL_LAST_BIT)
            begin
                shift_reg <= {shift_reg[14:0], serial_data_in};
                count_reg <= count_reg + 5'h01;
                if (count_reg == `DSL_LAST_BIT)
                begin
                    word_valid <= 1'b1;
                    word_data  <= {shift_reg[14:0], serial_data_in};
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/dsl_sync_pipe.v
// Two stage word pipeline with bypass.
// Assumes the enable changes only between words.
`timescale 1ns/1ns
`default_nettype none
`include "dsl_defs.vh"
module dsl_sync_pipe (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        enable,
    input  wire        in_valid,
    input  wire [15:0] in_word,
    output wire        out_valid,
    output wire [15:0] out_word
);
    reg        v1_reg;
    reg        v2_reg;
    reg [15:0] w1_reg;
    reg [15:0] w2_reg;

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
            w1_reg <= 16'h0000;
            w2_reg <= 16'h0000;
        end
        else
        begin
            v1_reg <= in_valid;
            v2_reg <= v1_reg;
            w1_reg <= in_word;
            w2_reg <= w1_reg;
        end
    end

    assign out_valid = enable ? v2_reg : in_valid;
    assign out_word  = enable ? w2_reg : in_word;
endmodule
`default_nettype wire

// >>> src/dsl_core.v
// Serial load control, register file and phase accumulator.
// Assumes an APB master on the clk domain and a host on the serial pins.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dsl_defs.vh"
module dsl_core (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        sclk,
    input  wire        serial_data_in,
    input  wire        frame_sync_n,
    input  wire        freq_choice,
    input  wire        phase_choice_lo,
    input  wire        phase_choice_hi,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    output reg  [11:0] phase_addr_out,
    output reg         sleep_out
);
    wire        rx_valid;
    wire [15:0] rx_word;
    wire        word_valid;
    wire [15:0] word;

    reg         serial_enable_reg;
    reg         sync_enable_reg;
    reg         choice_source_reg;
    reg         sleep_reg;
    reg         reset_ctl_reg;
    reg         reset_dly_reg;
    reg         freq_bit_reg;
    reg  [1:0]  phase_bits_reg;

    reg  [15:0] defer_reg;
    reg  [15:0] data_reg;
    reg  [3:0]  dest_addr_reg;
    reg         dest_freq_reg;
    reg         dest_pending_reg;

    reg  [15:0] freq_mem [0:3];
    reg  [11:0] phase_mem [0:3];

    reg  [2:0]  pin_s1_reg;
    reg  [2:0]  pin_s2_reg;
    reg  [2:0]  pin_s3_reg;
    reg         freq_sel_reg;
    reg  [1:0]  phase_sel_reg;
    reg  [11:0] phase_word_reg;
    reg  [31:0] acc_reg;
    reg  [11:0] sum_reg;
    reg  [11:0] out_d1_reg;

    wire [3:0]  cmd  = word[15:12];
    wire [3:0]  addr = word[11:8];
    wire [7:0]  dbyte = word[7:0];
    wire [2:0]  pins_eff;
    wire [2:0]  choice;
    wire [31:0] freq_word;
    wire        apb_setup = psel & ~penable & ~pready;
    wire        apb_write = psel & penable & pready & pwrite;

    function [15:0] merge_byte;
        input [15:0] old;
        input [7:0]  value;
        input        upper;
        begin
            if (upper)
                merge_byte = {value, old[7:0]};
            else
                merge_byte = {old[15:8], value};
        end
    endfunction

    function [31:0] read_mux;
        input [11:0] offset;
        input [31:0] status;
        begin
            if (offset == `DSL_OFF_STATUS)
                read_mux = status;
            else if (offset == `DSL_OFF_PHASE)
                read_mux = {20'h0_0000, phase_addr_out};
            else if (offset == `DSL_OFF_ACC)
                read_mux = acc_reg;
            else if (offset == `DSL_OFF_FREQ)
                read_mux = freq_word;
            else if (offset == `DSL_OFF_CTRL)
                read_mux = {31'h0000_0000, serial_enable_reg};
            else
                read_mux = 32'h0000_0000;
        end
    endfunction

    function is_mapped;
        input [11:0] offset;
        begin
            is_mapped = (offset == `DSL_OFF_STATUS) || (offset == `DSL_OFF_PHASE) ||
                        (offset == `DSL_OFF_ACC) || (offset == `DSL_OFF_FREQ) ||
                        (offset == `DSL_OFF_CTRL);
        end
    endfunction

    dsl_serial_rx u_rx (
        .clk            (clk),
        .reset_n        (reset_n),
        .sclk           (sclk),
        .serial_data_in (serial_data_in),
        .frame_sync_n   (frame_sync_n),
        .word_valid     (rx_valid),
        .word_data      (rx_word)
    );

    dsl_sync_pipe u_pipe (
        .clk       (clk),
        .reset_n   (reset_n),
        .enable    (sync_enable_reg),
        .in_valid  (rx_valid & serial_enable_reg),
        .in_word   (rx_word),
        .out_valid (word_valid),
        .out_word  (word)
    );

    // APB slave with no wait states; pready is raised in the first access cycle.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            pready            <= 1'b0;
            prdata            <= 32'h0000_0000;
            pslverr           <= 1'b0;
            serial_enable_reg <= `DSL_CTRL_RESET;
        end
        else
        begin
            pready <= apb_setup;
            if (apb_setup)
            begin
                pslverr <= ~is_mapped(paddr);
                prdata  <= pwrite ? 32'h0000_0000 :
                           read_mux(paddr, {25'h000_0000, phase_sel_reg, freq_sel_reg,
                                            reset_ctl_reg, sleep_reg, choice_source_reg,
                                            sync_enable_reg});
            end
            else
            begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
            if (apb_write && paddr == `DSL_OFF_CTRL)
                serial_enable_reg <= pwdata[0];
        end
    end

    // Control words: sync, source, sleep, reset and clear.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            sync_enable_reg   <= 1'b0;
            choice_source_reg <= 1'b0;
            sleep_reg         <= 1'b0;
            reset_ctl_reg     <= `DSL_RESET_CTL_INIT;
            reset_dly_reg     <= `DSL_RESET_CTL_INIT;
            freq_bit_reg      <= 1'b0;
            phase_bits_reg    <= 2'h0;
        end
        else
        begin
            reset_dly_reg <= reset_ctl_reg;
            if (word_valid)
            begin
                if (cmd[3:2] == `DSL_TOP_SYNC_SRC)
                begin
                    sync_enable_reg   <= word[`DSL_BIT_SYNC];
                    choice_source_reg <= word[`DSL_BIT_SOURCE];
                end
                else if (cmd[3:2] == `DSL_TOP_POWER)
                begin
                    sleep_reg     <= word[`DSL_BIT_SLEEP];
                    reset_ctl_reg <= word[`DSL_BIT_RESET];
                    if (word[`DSL_BIT_CLEAR])
                    begin
                        sync_enable_reg   <= 1'b0;
                        choice_source_reg <= 1'b0;
                    end
                end
                else if (cmd == `DSL_CMD_SEL_BITS)
                begin
                    freq_bit_reg   <= word[`DSL_BIT_FCHOICE];
                    phase_bits_reg <= word[10:9];
                end
            end
        end
    end

    // Defer register and data register loading.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            defer_reg        <= 16'h0000;
            data_reg         <= 16'h0000;
            dest_addr_reg    <= 4'h0;
            dest_freq_reg    <= 1'b0;
            dest_pending_reg <= 1'b0;
        end
        else
        begin
            dest_pending_reg <= 1'b0;
            if (word_valid && (cmd == `DSL_CMD_PH_DEFER || cmd == `DSL_CMD_FR_DEFER))
            begin
                defer_reg <= merge_byte(defer_reg, dbyte, addr[`DSL_ADDR_UPPER]);
            end
            else if (word_valid && (cmd == `DSL_CMD_PH_DIRECT || cmd == `DSL_CMD_FR_DIRECT))
            begin
                defer_reg        <= merge_byte(defer_reg, dbyte, addr[`DSL_ADDR_UPPER]);
                data_reg         <= merge_byte(defer_reg, dbyte, addr[`DSL_ADDR_UPPER]);
                dest_addr_reg    <= addr;
                dest_freq_reg    <= (cmd == `DSL_CMD_FR_DIRECT);
                dest_pending_reg <= 1'b1;
            end
        end
    end

    // Destination registers load one clock after the data register.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            freq_mem[0]  <= 16'h0000;
            freq_mem[1]  <= 16'h0000;
            freq_mem[2]  <= 16'h0000;
            freq_mem[3]  <= 16'h0000;
            phase_mem[0] <= 12'h000;
            phase_mem[1] <= 12'h000;
            phase_mem[2] <= 12'h000;
            phase_mem[3] <= 12'h000;
        end
        else if (dest_pending_reg)
        begin
            if (dest_freq_reg)
                freq_mem[dest_addr_reg[2:1]] <= data_reg;
            else
                phase_mem[dest_addr_reg[2:1]] <= data_reg[11:0];
        end
    end

    assign pins_eff = sync_enable_reg ? pin_s3_reg : pin_s1_reg;
    assign choice = choice_source_reg ? {phase_bits_reg, freq_bit_reg} : pins_eff;
    assign freq_word = {freq_mem[{freq_sel_reg, 1'b1}], freq_mem[{freq_sel_reg, 1'b0}]};

    // Selection path and phase accumulator.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            pin_s1_reg     <= 3'h0;
            pin_s2_reg     <= 3'h0;
            pin_s3_reg     <= 3'h0;
            freq_sel_reg   <= 1'b0;
            phase_sel_reg  <= 2'h0;
            phase_word_reg <= 12'h000;
            acc_reg        <= 32'h0000_0000;
            sum_reg        <= 12'h000;
            out_d1_reg     <= 12'h000;
            phase_addr_out <= 12'h000;
            sleep_out      <= 1'b0;
        end
        else
        begin
            pin_s1_reg     <= {phase_choice_hi, phase_choice_lo, freq_choice};
            pin_s2_reg     <= pin_s1_reg;
            pin_s3_reg     <= pin_s2_reg;
            freq_sel_reg   <= choice[0];
            phase_sel_reg  <= choice[2:1];
            phase_word_reg <= phase_mem[phase_sel_reg];
            sleep_out      <= sleep_reg;
            if (reset_dly_reg)
                acc_reg <= 32'h0000_0000;
            else if (!sleep_reg)
                acc_reg <= acc_reg + freq_word;
            sum_reg        <= acc_reg[31:20] + phase_word_reg;
            out_d1_reg     <= sum_reg;
            phase_addr_out <= out_d1_reg;
        end
    end
endmodule
`default_nettype wire

// >>> tb/dsl_host_model.sv
// Host serial port model that frames words onto the three-wire link.
// Assumes it is stepped from the bench right after rising clk edges.
`timescale 1ns/1ns
`default_nettype none
module dsl_host_model (
    input  wire logic clk,
    output var  logic sclk,
    output var  logic serial_data_in,
    output var  logic frame_sync_n
);
    initial
    begin
        sclk = 1'b0;
        serial_data_in = 1'b0;
        frame_sync_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input logic [15:0] wd, input int nbits, input logic [1:0] idle);
        int i;
        if (idle == 2'h2)
            repeat (4)
            begin
                sclk <= ~sclk;
                tick(2);
            end
        frame_sync_n <= 1'b0;
        tick(2);
        for (i = 15; i > 15 - nbits; i--)
        begin
            serial_data_in <= wd[i];
            sclk <= 1'b1;
            tick(2);
            sclk <= 1'b0;
            tick(2);
        end
        frame_sync_n <= 1'b1;
        serial_data_in <= ~serial_data_in;
        sclk <= idle[0];
        tick(6);
    endtask
endmodule
`default_nettype wire

// >>> tb/dsl_core_checker.sv
// Checker for the serial load control core ports.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module dsl_core_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        frame_sync_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [11:0] phase_addr_out,
    input wire logic        sleep_out
);
    logic [3:0] idle_cnt;
    logic       mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h010);
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            idle_cnt <= 4'hf;
        else if (!frame_sync_n)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf)
            idle_cnt <= idle_cnt + 4'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    apb_answer_a: assert property ((psel && !penable) |=> pready)
        else $error("no answer after setup");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    apb_access_a: assert property (pready |-> (psel && penable))
        else $error("ready outside access");
    unmapped_err_a: assert property ((psel && !penable && !mapped) |=> (pslverr && prdata == 32'h0))
        else $error("unmapped not refused");
    mapped_ok_a: assert property ((psel && !penable && mapped) |=> !pslverr)
        else $error("mapped access refused");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    reset_quiet_a: assert property ($rose(reset_n) |-> (phase_addr_out == 12'h000)[*8])
        else $error("output moved after reset");
    sleep_source_a: assert property ($changed(sleep_out) |-> idle_cnt < 4'hc)
        else $error("sleep changed without word");
endmodule
bind dsl_core dsl_core_checker dsl_core_checker_inst (.clk(clk), .reset_n(reset_n),
    .frame_sync_n(frame_sync_n), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .phase_addr_out(phase_addr_out), .sleep_out(sleep_out));
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the serial load control core.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        freq_choice;
    logic [1:0]  phase_choice;
    wire         sclk;
    wire         serial_data_in;
    wire         frame_sync_n;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire  [11:0] phase_addr_out;
    wire         sleep_out;
    int          error_cnt;
    int          n_tests;
    int          n_sent;
    int          i;
    logic [31:0] rdat;
    logic [31:0] a1;
    logic        perr;
    logic [15:0] fw [4];
    logic [11:0] pw [4];
    dsl_core dsl_core_inst (.clk(clk), .reset_n(reset_n), .sclk(sclk),
        .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n),
        .freq_choice(freq_choice), .phase_choice_lo(phase_choice[0]),
        .phase_choice_hi(phase_choice[1]), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phase_addr_out(phase_addr_out), .sleep_out(sleep_out));
    dsl_host_model dsl_host_model_inst (.clk(clk), .sclk(sclk),
        .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] sel_freq(input logic c);
        return c ? {fw[3], fw[2]} : {fw[1], fw[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rdat, exp);
    endtask
    task automatic send(input logic [15:0] wd);
        dsl_host_model_inst.send(wd, 16, 2'(n_sent % 3));
        n_sent++;
    endtask
    task automatic load_freq(input logic [1:0] idx, input logic [15:0] v);
        send({4'h2, 1'b0, idx, 1'b1, v[15:8]});
        send({4'h3, 1'b0, idx, 1'b0, v[7:0]});
    endtask
    task automatic load_phase(input logic [1:0] idx, input logic [11:0] v);
        send({4'h0, 1'b0, idx, 1'b1, 4'h0, v[11:8]});
        send({4'h1, 1'b0, idx, 1'b0, v[7:0]});
    endtask
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        freq_choice = 1'b0;
        phase_choice = 2'h0;
        error_cnt = 0;
        n_tests = 0;
        n_sent = 0;
        void'($urandom(32'hdb2f));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk("status", 12'h000, 32'h0000_0008);
        rd_chk("ctrl", 12'h010, 32'h0000_0001);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped err", {31'h0, perr}, 32'h1);
        $display("test reset done");
        send(16'hd800);
        send({4'h2, 4'h1, 8'ha5});
        rd_chk("deferred only", 12'h00c, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            fw[i] = 16'($urandom);
            pw[i] = 12'($urandom);
            load_freq(i[1:0], fw[i]);
            load_phase(i[1:0], pw[i]);
        end
        for (i = 0; i < 8; i++)
        begin
            freq_choice <= i[2];
            phase_choice <= i[1:0];
            repeat (10) @(posedge clk);
            rd_chk("freq word", 12'h00c, sel_freq(i[2]));
            rd_chk("phase out", 12'h004, {20'h0, pw[i[1:0]]});
            check("phase pin", {20'h0, phase_addr_out}, {20'h0, pw[i[1:0]]});
            rd_chk("status pins", 12'h000, {25'h0, i[1:0], i[2], 4'h8});
        end
        $display("test load done");
        dsl_host_model_inst.send({4'h3, 4'h4, 8'h5a}, 10, 2'h1);
        rd_chk("short frame", 12'h00c, sel_freq(1'b1));
        apb(1'b1, 12'h010, 32'h0);
        send({4'h3, 4'h4, 8'h5a});
        rd_chk("ctrl off", 12'h010, 32'h0);
        rd_chk("dropped word", 12'h00c, sel_freq(1'b1));
        apb(1'b1, 12'h010, 32'h1);
        $display("test refuse done");
        send(16'h9000);
        send(16'h6400);
        rd_chk("status bits", 12'h000, 32'h0000_004a);
        rd_chk("bit freq", 12'h00c, sel_freq(1'b0));
        rd_chk("bit phase", 12'h004, {20'h0, pw[2]});
        send(16'hb000);
        rd_chk("sync on", 12'h000, 32'h0000_004b);
        fw[0] = 16'($urandom);
        load_freq(2'h0, fw[0]);
        rd_chk("sync load", 12'h00c, sel_freq(1'b0));
        send(16'hd800);
        rd_chk("cleared", 12'h000, 32'h0000_0078);
        $display("test select done");
        send(16'hc000);
        apb(1'b0, 12'h008, 32'h0);
        a1 = rdat;
        apb(1'b0, 12'h008, 32'h0);
        check("acc step", rdat - a1, 32'h3 * sel_freq(1'b1));
        send(16'he000);
        check("sleep pin", {31'h0, sleep_out}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        a1 = rdat;
        apb(1'b0, 12'h008, 32'h0);
        check("acc frozen", rdat - a1, 32'h0);
        send(16'hd000);
        rd_chk("acc zero", 12'h008, 32'h0);
        rd_chk("freq kept", 12'h00c, sel_freq(1'b1));
        $display("test run done");
        give_verdict();
    end
endmodule
`default_nettype wire
